// *** hw/pwmsd_top.sv ***
// pwmsd_top: dead-band and auto-shutdown stage of an enhanced pwm unit
// assumes: pwm_a..d and period_start come from the period/duty logic,
// comparator and fault inputs are synchronous to sys_clk_i
`timescale 1ns/1ps
module pwmsd_top
  import pwmsd_pkg::*;
#(
  parameter int DB_W = 7
) (
  input  wire logic       sys_clk_i,
  input  wire logic       nrst_i,
  // register port
  input  wire logic [2:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // pwm inputs from period/duty logic
  input  wire logic       pwm_a_i,
  input  wire logic       pwm_b_i,
  input  wire logic       pwm_c_i,
  input  wire logic       pwm_d_i,
  input  wire logic       period_start_i,
  // shutdown sources
  input  wire logic       fault_input_low_n_i,
  input  wire logic       comp1_i,
  input  wire logic       comp2_i,
  // output pins: value and active-low output enable
  output logic      [3:0] pin_out_o,
  output logic      [3:0] pin_oe_n_o,
  output logic            irq_o
);
  // register field is fixed at 7 bits, refuse other widths
  if (DB_W != 7) begin : g_bad_db_w
    $error("pwmsd_top: DB_W must be 7");
  end

  // ---------------------------------------------------------------
  // source decode
  // ---------------------------------------------------------------
  function automatic logic cause_active(input logic [2:0] sel,
                                        input logic f_n,
                                        input logic c1,
                                        input logic c2);
    logic r;
    r = 1'b0;
    unique case (pwmsd_src_e'(sel))
      PWMSD_SRC_OFF:     r = 1'b0;
      PWMSD_SRC_C1:      r = c1;
      PWMSD_SRC_C2:      r = c2;
      PWMSD_SRC_C1_C2:   r = c1 | c2;
      PWMSD_SRC_F:       r = ~f_n;
      PWMSD_SRC_F_C1:    r = ~f_n | c1;
      PWMSD_SRC_F_C2:    r = ~f_n | c2;
      PWMSD_SRC_F_C1_C2: r = ~f_n | c1 | c2;
    endcase
    return r;
  endfunction : cause_active

  // pin level and enable for one pair in shutdown
  function automatic logic [1:0] sd_pin(input logic [1:0] st);
    // bit1 = oe_n, bit0 = level
    return st[1] ? 2'b10 : {1'b0, st[0]};
  endfunction : sd_pin

  // ---------------------------------------------------------------
  // registers and state
  // ---------------------------------------------------------------
  logic       restart_en_q, restart_en_d;
  logic [6:0] db_count_q, db_count_d;
  logic       flag_q, flag_d;
  logic [2:0] src_q, src_d;
  logic [1:0] ac_st_q, ac_st_d;
  logic [1:0] bd_st_q, bd_st_d;
  logic       hold_q, hold_d;
  logic [1:0] irq_st_q, irq_st_d;
  logic [1:0] irq_en_q, irq_en_d;
  logic [7:0] rdata_q, rdata_d;
  logic [1:0] tcy_q, tcy_d;
  logic       irq_q, irq_d;
  logic [3:0] pout_q, pout_d;
  logic [3:0] poe_q, poe_d;
  logic       cause;
  logic       wr_ctl;
  logic [3:0] db_pwm;

  assign cause  = cause_active(src_q, fault_input_low_n_i, comp1_i, comp2_i);
  assign wr_ctl = reg_wr_i && (reg_addr_i == OFS_SHUTDOWN_CTL);

  // ---------------------------------------------------------------
  // dead-band delay per output
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 4; i++) begin : g_db
    logic pin_in;
    assign pin_in = (i == 0) ? pwm_a_i : (i == 1) ? pwm_b_i :
                    (i == 2) ? pwm_c_i : pwm_d_i;
    pwmsd_deadband #(.CNT_W(DB_W)) u_db (
      .sys_clk_i  (sys_clk_i),
      .nrst_i     (nrst_i),
      .tcy_tick_i (tcy_q == 2'(TCY_OSC_PERIODS - 1)),
      .delay_i    (db_count_q),
      .pwm_i      (pin_in),
      .pwm_o      (db_pwm[i])
    );
  end

  // ---------------------------------------------------------------
  // register writes, shutdown flag and interrupt status
  // ---------------------------------------------------------------
  always_comb begin
    restart_en_d = restart_en_q;
    db_count_d   = db_count_q;
    flag_d       = flag_q;
    src_d        = src_q;
    ac_st_d      = ac_st_q;
    bd_st_d      = bd_st_q;
    irq_en_d     = irq_en_q;
    irq_st_d     = irq_st_q;
    tcy_d        = (tcy_q == 2'(TCY_OSC_PERIODS - 1)) ? 2'h0 : tcy_q + 2'h1;
    if (reg_wr_i && reg_addr_i == OFS_RESTART_DB) begin
      restart_en_d = reg_wdata_i[BIT_RESTART_EN];
      db_count_d   = reg_wdata_i[6:0];
    end
    if (wr_ctl) begin
      src_d   = reg_wdata_i[BIT_SRC_LO +: 3];
      ac_st_d = reg_wdata_i[BIT_AC_LO +: 2];
      bd_st_d = reg_wdata_i[BIT_BD_LO +: 2];
      if (!cause) begin
        flag_d = reg_wdata_i[BIT_EVENT_FLAG];
      end
    end
    if (cause) begin
      flag_d = 1'b1;
    end else if (restart_en_q && flag_q) begin
      flag_d = 1'b0;
    end
    if (reg_wr_i && reg_addr_i == OFS_IRQ_ENABLE) begin
      irq_en_d = reg_wdata_i[1:0];
    end
    if (reg_wr_i && reg_addr_i == OFS_IRQ_CLEAR) begin
      irq_st_d = irq_st_q & ~reg_wdata_i[1:0];
    end
    // set wins over clear
    if (flag_d && !flag_q) begin
      irq_st_d[IRQ_SHUTDOWN] = 1'b1;
    end
    if (hold_q && !hold_d) begin
      irq_st_d[IRQ_RESTART] = 1'b1;
    end
    irq_d = |(irq_st_d & irq_en_d);
  end

  // output hold: set with the flag, released at a period start
  always_comb begin
    hold_d = hold_q;
    if (flag_d) begin
      hold_d = 1'b1;
    end else if (period_start_i) begin
      hold_d = 1'b0;
    end
  end

  // pin drive: shutdown state or dead-banded pwm
  always_comb begin
    if (hold_d) begin
      {poe_d[0], pout_d[0]} = sd_pin(ac_st_d);
      {poe_d[2], pout_d[2]} = sd_pin(ac_st_d);
      {poe_d[1], pout_d[1]} = sd_pin(bd_st_d);
      {poe_d[3], pout_d[3]} = sd_pin(bd_st_d);
    end else begin
      pout_d = db_pwm;
      poe_d  = 4'h0;
    end
  end

  // read mux, data one cycle after the strobe
  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        OFS_RESTART_DB:   rdata_d = {restart_en_q, db_count_q};
        OFS_SHUTDOWN_CTL: rdata_d = {flag_q, src_q, ac_st_q, bd_st_q};
        OFS_IRQ_STATUS:   rdata_d = {6'h00, irq_st_q};
        OFS_IRQ_ENABLE:   rdata_d = {6'h00, irq_en_q};
        default:          rdata_d = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      restart_en_q <= RST_RESTART_DB[7];
      db_count_q   <= RST_RESTART_DB[6:0];
      flag_q       <= RST_SHUTDOWN_CTL[7];
      src_q        <= RST_SHUTDOWN_CTL[6:4];
      ac_st_q      <= RST_SHUTDOWN_CTL[3:2];
      bd_st_q      <= RST_SHUTDOWN_CTL[1:0];
      hold_q       <= 1'b0;
      irq_st_q     <= 2'h0;
      irq_en_q     <= 2'h0;
      rdata_q      <= 8'h00;
      tcy_q        <= 2'h0;
      irq_q        <= 1'b0;
      pout_q       <= 4'h0;
      poe_q        <= 4'hF;
    end else begin
      restart_en_q <= restart_en_d;
      db_count_q   <= db_count_d;
      flag_q       <= flag_d;
      src_q        <= src_d;
      ac_st_q      <= ac_st_d;
      bd_st_q      <= bd_st_d;
      hold_q       <= hold_d;
      irq_st_q     <= irq_st_d;
      irq_en_q     <= irq_en_d;
      rdata_q      <= rdata_d;
      tcy_q        <= tcy_d;
      irq_q        <= irq_d;
      pout_q       <= pout_d;
      poe_q        <= poe_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign pin_out_o   = pout_q;
  assign pin_oe_n_o  = poe_q;
  assign irq_o       = irq_q;
endmodule : pwmsd_top

// *** hw/pwmsd_pkg.sv ***
// pwmsd_pkg: constants for the pwm shutdown and dead-band block
// assumes: 8-bit register port, one clock domain
package pwmsd_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [2:0] OFS_RESTART_DB   = 3'h0;
  localparam logic [2:0] OFS_SHUTDOWN_CTL = 3'h1;
  localparam logic [2:0] OFS_IRQ_STATUS   = 3'h2;
  localparam logic [2:0] OFS_IRQ_ENABLE   = 3'h3;
  localparam logic [2:0] OFS_IRQ_CLEAR    = 3'h4;
  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int         BIT_RESTART_EN   = 7;
  localparam int         BIT_EVENT_FLAG   = 7;
  localparam int         BIT_SRC_LO       = 4;
  localparam int         BIT_AC_LO        = 2;
  localparam int         BIT_BD_LO        = 0;
  localparam logic [7:0] RST_RESTART_DB   = 8'h00;
  localparam logic [7:0] RST_SHUTDOWN_CTL = 8'h00;
  // irq status bits
  localparam int         IRQ_SHUTDOWN     = 0;
  localparam int         IRQ_RESTART      = 1;
  // instruction cycle: four oscillator periods, in system clocks
  localparam int         TCY_OSC_PERIODS  = 4;
  // ---------------------------------------------------------------
  // shutdown source codes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    PWMSD_SRC_OFF      = 3'b000,
    PWMSD_SRC_C1       = 3'b001,
    PWMSD_SRC_C2       = 3'b010,
    PWMSD_SRC_C1_C2    = 3'b011,
    PWMSD_SRC_F        = 3'b100,
    PWMSD_SRC_F_C1     = 3'b101,
    PWMSD_SRC_F_C2     = 3'b110,
    PWMSD_SRC_F_C1_C2  = 3'b111
  } pwmsd_src_e;
endpackage : pwmsd_pkg

// *** hw/pwmsd_deadband.sv ***
// pwmsd_deadband: delays the rising (inactive to active) edge of one
// pwm signal by a count of instruction cycles
// assumes: tcy_tick_i is one clock wide, once per instruction cycle
`timescale 1ns/1ps
module pwmsd_deadband
  import pwmsd_pkg::*;
#(
  parameter int CNT_W = 7
) (
  input  wire logic             sys_clk_i,
  input  wire logic             nrst_i,
  input  wire logic             tcy_tick_i,
  input  wire logic [CNT_W-1:0] delay_i,
  input  wire logic             pwm_i,
  output logic                  pwm_o
);
  // refuse counter widths the decrement logic was not sized for
  if (CNT_W < 1 || CNT_W > 16) begin : g_bad_cnt_w
    $error("pwmsd_deadband: bad CNT_W");
  end

  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             out_q, out_d;

  // falling edges pass at once, rising edges wait delay_i cycles
  always_comb begin
    cnt_d = cnt_q;
    out_d = out_q;
    if (!pwm_i) begin
      out_d = 1'b0;
      cnt_d = delay_i;
    end else if (!out_q) begin
      if (cnt_q == '0) begin
        out_d = 1'b1;
      end else if (tcy_tick_i) begin
        cnt_d = cnt_q - CNT_W'(1);
      end
    end
  end

  // state registers
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign pwm_o = out_q;
endmodule : pwmsd_deadband

// *** testbench/pwmsd_top_assertions.sv ***
// pwmsd_top_assertions: port-level checker for pwmsd_top
// assumes: register writes are mirrored from the register port
`timescale 1ns/1ps
module pwmsd_top_assertions
  import pwmsd_pkg::*;
#(
  parameter int DB_W = 7
) (
  input wire logic       sys_clk_i, nrst_i, reg_wr_i, reg_rd_i, irq_o,
  input wire logic       pwm_a_i, pwm_b_i, pwm_c_i, pwm_d_i,
  input wire logic       period_start_i, fault_input_low_n_i,
  input wire logic       comp1_i, comp2_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i, reg_rdata_o,
  input wire logic [3:0] pin_out_o, pin_oe_n_o
);
  logic [7:0] ctl_q, rdb_q;
  logic [9:0] hi_q, age_q;
  logic [2:0] wsel;
  logic       cs, rd1;
  // selected shutdown cause from the mirrored source field
  assign cs = (ctl_q[6] && !fault_input_low_n_i) ||
              (ctl_q[4] && comp1_i) || (ctl_q[5] && comp2_i);
  assign rd1 = reg_rd_i && reg_addr_i == OFS_SHUTDOWN_CTL;
  assign wsel = reg_wr_i ? reg_addr_i : 3'h7;
  // register mirror, pwm-high and quiet-time counters
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctl_q <= 8'h00;
      rdb_q <= 8'h00;
      hi_q  <= 10'h000;
      age_q <= 10'h000;
    end else begin
      if (wsel == OFS_SHUTDOWN_CTL) ctl_q <= reg_wdata_i;
      if (wsel == OFS_RESTART_DB) rdb_q <= reg_wdata_i;
      hi_q  <= pwm_b_i ? hi_q + {9'h000, hi_q != 10'h200} : 10'h000;
      age_q <= reg_wr_i ? 10'h000 : age_q + {9'h000, age_q != 10'h3FF};
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data not zero outside read answer");
  a_unmapped_zero: assert property (reg_rd_i && reg_addr_i > 3'h4 |=>
    reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  a_sd_pair_ac: assert property (cs && !reg_wr_i |=>
    (pin_oe_n_o[0] && pin_oe_n_o[2]) == ctl_q[3] && (ctl_q[3] ||
    (pin_out_o[0] == ctl_q[2] && pin_out_o[2] == ctl_q[2])))
    else $error("pair a/c not in shutdown state");
  a_sd_pair_bd: assert property (cs && !reg_wr_i |=>
    (pin_oe_n_o[1] && pin_oe_n_o[3]) == ctl_q[1] && (ctl_q[1] ||
    (pin_out_o[1] == ctl_q[0] && pin_out_o[3] == ctl_q[0])))
    else $error("pair b/d not in shutdown state");
  a_resume_at_start: assert property ($fell(pin_oe_n_o[1]) |->
    $past(period_start_i) || $past(reg_wr_i) || $past(reg_wr_i, 2) ||
    !$past(nrst_i, 2)) else $error("output resumed mid-period");
  a_deadband_min: assert property ($rose(pin_out_o[1]) &&
    !pin_oe_n_o[1] && !$past(pin_oe_n_o[1]) && ctl_q[1] &&
    age_q > 10'd520 |-> hi_q + 10'd2 >= {1'b0, rdb_q[6:0], 2'b00})
    else $error("rising edge came before dead-band");
  a_flag_set_read: assert property (cs ##1 rd1 |=> reg_rdata_o[7])
    else $error("event flag not set under cause");
  a_flag_wr_refused: assert property (cs && wsel == OFS_SHUTDOWN_CTL &&
    !reg_wdata_i[7] ##1 cs ##1 (cs && rd1) |=> reg_rdata_o[7])
    else $error("flag write taken during cause");
  a_flag_held: assert property ($fell(cs) && !rdb_q[7] && !reg_wr_i
    ##1 (rd1 && !cs) |=> reg_rdata_o[7])
    else $error("flag cleared without restart");
  c_shutdown: cover property (cs ##1 pin_oe_n_o[1]);
  c_flag_read: cover property (rd1 ##1 reg_rdata_o[7]);
  c_deadband: cover property ($rose(pin_out_o[1]) && age_q > 10'd520);
endmodule : pwmsd_top_assertions

bind pwmsd_top pwmsd_top_assertions #(.DB_W(DB_W)) u_chk (
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .irq_o(irq_o), .pwm_a_i(pwm_a_i),
  .pwm_b_i(pwm_b_i), .pwm_c_i(pwm_c_i), .pwm_d_i(pwm_d_i),
  .period_start_i(period_start_i),
  .fault_input_low_n_i(fault_input_low_n_i), .comp1_i(comp1_i),
  .comp2_i(comp2_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .pin_out_o(pin_out_o), .pin_oe_n_o(pin_oe_n_o));

// *** testbench/pwmsd_bridge_model.sv ***
// pwmsd_bridge_model: pwm source, fault pin and comparators
// assumes: trip_i bit 0 fault, bit 1 comparator 1, bit 2 comparator 2
`timescale 1ns/1ps
module pwmsd_bridge_model (
  input  wire logic       sys_clk_i,
  input  wire logic       nrst_i,
  input  wire logic [2:0] trip_i,
  input  wire logic [5:0] duty_i,
  output logic      [3:0] pwm_o,
  output logic            period_start_o,
  output logic            fault_n_o,
  output logic      [1:0] comp_o
);
  logic [5:0] cnt_q;
  // 64-clock period, a/c high for duty_i clocks, b/d complement
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= 6'h00;
    end else begin
      cnt_q <= cnt_q + 6'h01;
    end
  end
  assign period_start_o = cnt_q == 6'h00;
  assign pwm_o = {4{cnt_q < duty_i}} ^ 4'hA;
  assign fault_n_o = !trip_i[0]; // pulled-up pin, low on fault
  assign comp_o = trip_i[2:1];
endmodule : pwmsd_bridge_model

// *** testbench/tb_pwm_shutdown_deadband_config.sv ***
// tb_pwm_shutdown_deadband_config: self-checking bench for pwmsd_top
// assumes: bridge model drives pwm, period start, fault, comparators
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
  miscompares++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_pwm_shutdown_deadband_config
  import pwmsd_pkg::*;
;
  logic       sys_clk_i, nrst_i, reg_wr_i, reg_rd_i, irq_o, e;
  logic       pwm_a_i, pwm_b_i, pwm_c_i, pwm_d_i, period_start_i;
  logic       fault_input_low_n_i, comp1_i, comp2_i;
  logic [2:0] reg_addr_i, trip, c, s;
  logic [1:0] ac;
  logic [5:0] duty;
  logic [3:0] pin_out_o, pin_oe_n_o;
  logic [7:0] reg_wdata_i, reg_rdata_o, d;
  int         miscompares, tests_run, lat, n;
  integer     seed = 32'hFB39BF8B;
  pwmsd_bridge_model u_pwmsd_bridge_model (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .trip_i(trip), .duty_i(duty),
    .pwm_o({pwm_d_i, pwm_c_i, pwm_b_i, pwm_a_i}),
    .period_start_o(period_start_i), .fault_n_o(fault_input_low_n_i),
    .comp_o({comp2_i, comp1_i}));
  pwmsd_top #(.DB_W(7)) u_pwmsd_top (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .pwm_a_i(pwm_a_i), .pwm_b_i(pwm_b_i),
    .pwm_c_i(pwm_c_i), .pwm_d_i(pwm_d_i),
    .period_start_i(period_start_i),
    .fault_input_low_n_i(fault_input_low_n_i), .comp1_i(comp1_i),
    .comp2_i(comp2_i), .pin_out_o(pin_out_o), .pin_oe_n_o(pin_oe_n_o),
    .irq_o(irq_o));
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk_i);
  endtask : tick
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(posedge sys_clk_i);
    v = reg_rdata_o;
  endtask : rd
  // expected shutdown for a source code and trip lines
  function automatic logic exp_sd(logic [2:0] cd, logic [2:0] t);
    return (cd[2] & t[0]) | (cd[0] & t[1]) | (cd[1] & t[2]);
  endfunction : exp_sd
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict
  initial begin
    {reg_wr_i, reg_rd_i, nrst_i, reg_addr_i, trip} = 9'h000;
    reg_wdata_i = 8'h00;
    duty = {2'b01, 4'($random(seed))};
    tick(16);
    nrst_i <= 1'b1;
    wr(3'h5, 8'hFF);
    for (int i = 0; i < 8; i++) begin
      rd(3'(i), d);
      `CHK(d, 8'h00)
    end
    $display("test reset_map done");
    for (int i = 0; i < 24; i++) begin
      c = 3'(i / 3);
      s = 3'b001 << (i % 3);
      ac = c[1:0] ^ 2'(i);
      wr(OFS_SHUTDOWN_CTL, {1'b0, c, ac, ac ^ 2'b10});
      @(posedge sys_clk_i) trip <= s;
      tick(2);
      e = exp_sd(c, s);
      `CHK(pin_oe_n_o[1], e & ~ac[1])
      `CHK(pin_oe_n_o[0], e & ac[1])
      if (e && !ac[1]) `CHK(pin_out_o[2], ac[0])
      if (e && ac[1]) `CHK(pin_out_o[3], ac[0])
      rd(OFS_SHUTDOWN_CTL, d);
      `CHK(d[7], e)
      @(posedge sys_clk_i) trip <= 3'h0;
      wr(OFS_SHUTDOWN_CTL, 8'h02);
      tick(70);
    end
    $display("test source_table done");
    wr(OFS_SHUTDOWN_CTL, 8'h42);
    @(posedge sys_clk_i) trip <= 3'h1;
    tick(3);
    wr(OFS_SHUTDOWN_CTL, 8'h42);
    rd(OFS_SHUTDOWN_CTL, d);
    `CHK(d[7], 1'b1)
    @(posedge sys_clk_i) trip <= 3'h0;
    rd(OFS_SHUTDOWN_CTL, d);
    `CHK(d[7], 1'b1)
    @(posedge period_start_i);
    wr(OFS_SHUTDOWN_CTL, 8'h42);
    `CHK(pin_oe_n_o[1], 1'b1)
    @(posedge period_start_i);
    tick(2);
    `CHK(pin_oe_n_o[1], 1'b0)
    $display("test manual_restart done");
    wr(OFS_RESTART_DB, 8'h80);
    wr(OFS_IRQ_CLEAR, 8'h03);
    wr(OFS_IRQ_ENABLE, 8'h01);
    @(posedge sys_clk_i) trip <= 3'h1;
    `CHK(irq_o, 1'b0)
    tick(3);
    `CHK(irq_o, 1'b1)
    @(posedge sys_clk_i) trip <= 3'h0;
    tick(3);
    rd(OFS_SHUTDOWN_CTL, d);
    `CHK(d[7], 1'b0)
    wr(OFS_IRQ_ENABLE, 8'h00);
    tick(2);
    `CHK(irq_o, 1'b0)
    tick(70);
    rd(OFS_IRQ_STATUS, d);
    `CHK(d, 8'h03)
    wr(OFS_IRQ_CLEAR, 8'h03);
    wr(OFS_IRQ_ENABLE, 8'h03);
    rd(OFS_IRQ_STATUS, d);
    `CHK(d, 8'h00)
    `CHK(irq_o, 1'b0)
    $display("test auto_restart_irq done");
    n = 1 + ($unsigned($random(seed)) % 7);
    wr(OFS_RESTART_DB, 8'(n));
    tick(700);
    @(posedge pwm_b_i);
    lat = 0;
    while (pin_out_o[1] !== 1'b1 && lat < 100) begin
      @(posedge sys_clk_i);
      lat++;
    end
    `CHK(lat >= 4 * n - 1 && lat <= 4 * n + 4, 1'b1)
    $display("test deadband done");
    print_verdict();
  end
  initial begin
    tick(20000);
    miscompares++;
    print_verdict();
  end
endmodule : tb_pwm_shutdown_deadband_config
